// *** design/scd_consts.vh ***
/*
  constants for the strobe command decoder: command codes, addresses,
  mode encodings and reset values.
  assumes inclusion by bare name from the design files.
*/
`ifndef SCD_CONSTS_VH
`define SCD_CONSTS_VH

// first-byte fields
`define SCD_CMD_BIT 7
`define SCD_RW_BIT 6
// strobe nibbles
`define SCD_STB_SLEEP 4'h8
`define SCD_STB_IDLE 4'h9
`define SCD_STB_STBY 4'hA
`define SCD_STB_PLL 4'hB
`define SCD_STB_RX 4'hC
`define SCD_STB_TX 4'hD
`define SCD_STB_WPRST 4'hE
`define SCD_STB_RPRST 4'hF
// full deep sleep codes
`define SCD_DS_TRI 8'h88
`define SCD_DS_PULL 8'h8B
// register addresses
`define SCD_ADDR_RST 6'h00
`define SCD_ADDR_FIFO 6'h05
`define SCD_ADDR_ID 6'h06
// output function select value for fifo status
`define SCD_GSEL_FIFO 4'h1
// spi data out function select value (4-wire)
`define SCD_GSEL_SDO 4'h6
// operating modes, one-hot
`define SCD_MODE_W 8
`define SCD_M_DEEP 8'h01
`define SCD_M_SLEEP 8'h02
`define SCD_M_IDLE 8'h04
`define SCD_M_STBY 8'h08
`define SCD_M_PLL 8'h10
`define SCD_M_RX 8'h20
`define SCD_M_TX 8'h40
// reset values
`define SCD_ID_RST 32'h00000000
`define SCD_SRST_CYCLES 4'h4

`endif

// *** design/scd_sync2.v ***
/*
  two flip-flop synchroniser for one level from outside the core clock.
  assumes an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module scd_sync2 #(
  parameter RST_VAL = 1'b0
) (
  input wire core_clk,
  input wire rst_n,
  input wire d,
  output reg q
);
  reg meta_r;

  // first stage read only by the second
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // scd_sync2

// *** design/scd_strobe_decoder.v ***
/*
  serial command interpreter: strobes, software reset, id access and
  fifo burst access, with power-domain enables per operating mode.
  assumes serial clock, select and data come from the host on pins and
  are oversampled by core_clk (at least 8x the serial clock rate).
*/
`timescale 1ns/1ps
`include "scd_consts.vh"

// Overview of operation
// - first bit one is strobe; zero is register access, then r/w bit, 6-bit address
// - input sampled on rising serial clock, read data shifted on falling edge
// - strobe accepted as 4-bit code or full 8-bit code
// - in 8-bit form low nibble ignored; select may stay low for more commands
// - strobe decoding only while both alternate strobe config bits are zero
// - code 1000 enters sleep
// - code 1001 enters idle: regulator on, oscillator and radio off
// - code 1010 enters standby: regulator and crystal on, radio off
// - code 1011 enters pll mode: oscillator, vco, pll on; rx and tx off
// - code 1100 enters receive: synthesizer and receiver on, transmitter off
// - code 1101 enters transmit: synthesizer and transmitter on, receiver off
// - code 1110 resets fifo write pointer, mode unchanged
// - code 1111 resets fifo read pointer, mode unchanged
// - 10001000 tristates both outputs, 10001011 pulls them up
// - deep sleep powers all off and loses register contents
// - write of zero address and zero data fires internal reset, then standby
// - after any reset registers take initial values; calibration needed again
// - id write: address 06h then four id bytes, order 0 to 3
// - id read: address 46h then four id bytes out, order 0 to 3
// - fifo write: address 05h then bytes stored sequentially
// - fifo read: address 45h then bytes streamed until select rises
// - fifo data mode when fifo mode select is one, else direct
// - fifo status driven on an output whose function select picks it
// - sleep keeps registers, regulator on, everything else off
module scd_strobe_decoder #(
  parameter SRST_CYCLES = `SCD_SRST_CYCLES
) (
  input wire core_clk,
  input wire rst_n,
  input wire serial_select_n,
  input wire serial_clk,
  input wire serial_data_in,
  output reg serial_data_out,
  output reg serial_data_oe_n,
  input wire alt_strobe_cfg_a,
  input wire alt_strobe_cfg_b,
  input wire fifo_mode_select,
  input wire [3:0] output1_function_select,
  input wire [3:0] output2_function_select,
  input wire fifo_status,
  input wire [7:0] rx_fifo_data,
  output reg rx_fifo_pop,
  output reg [7:0] tx_fifo_data,
  output reg tx_fifo_push,
  output reg fifo_wptr_rst,
  output reg fifo_rptr_rst,
  output reg fifo_data_mode,
  output reg [31:0] id_value,
  output reg [`SCD_MODE_W-1:0] op_mode,
  output reg regulator_en,
  output reg xtal_en,
  output reg vco_en,
  output reg pll_en,
  output reg rx_en,
  output reg tx_en,
  output reg recal_needed,
  output reg internal_reset_n,
  output reg general_output_1,
  output reg general_output_1_oe_n,
  output reg general_output_1_pullup,
  output reg general_output_2,
  output reg general_output_2_oe_n,
  output reg general_output_2_pullup
);
  // phase states, one-hot
  localparam ST_CMD = 5'b00001;
  localparam ST_ADDR = 5'b00010;
  localparam ST_WDATA = 5'b00100;
  localparam ST_RDATA = 5'b01000;
  localparam ST_DONE = 5'b10000;

  wire cs_n_s;
  wire sck_s;
  wire sdi_s;
  reg sck_d_r;
  reg [4:0] st_r;
  reg [2:0] bitcnt_r;
  reg [7:0] shift_r;
  reg [7:0] addr_r;
  reg [1:0] bytecnt_r;
  reg [7:0] rd_shift_r;
  reg rd_active_r;
  reg [3:0] srst_cnt_r;
  reg io_tri_r;
  reg io_pull_r;

  scd_sync2 #(.RST_VAL(1'b1)) u_sync_cs (
    .core_clk(core_clk), .rst_n(rst_n), .d(serial_select_n), .q(cs_n_s));
  scd_sync2 #(.RST_VAL(1'b0)) u_sync_sck (
    .core_clk(core_clk), .rst_n(rst_n), .d(serial_clk), .q(sck_s));
  scd_sync2 #(.RST_VAL(1'b0)) u_sync_sdi (
    .core_clk(core_clk), .rst_n(rst_n), .d(serial_data_in), .q(sdi_s));

  // edges are seen only on the synchronised copy
  wire sck_rise = sck_s & ~sck_d_r;
  wire sck_fall = ~sck_s & sck_d_r;
  wire active = ~cs_n_s;
  wire [7:0] byte_in = {shift_r[6:0], sdi_s};
  wire strobes_on = ~alt_strobe_cfg_a & ~alt_strobe_cfg_b;
  wire srst_busy = (srst_cnt_r != 4'h0);

  // one byte of the id register picked by byte count, byte 0 in [31:24]
  function [7:0] id_byte;
    input [31:0] idv;
    input [1:0] idx;
    begin
      case (idx)
        2'd0: id_byte = idv[31:24];
        2'd1: id_byte = idv[23:16];
        2'd2: id_byte = idv[15:8];
        default: id_byte = idv[7:0];
      endcase
    end
  endfunction

  // enter a mode and set the power-domain enables that belong to it
  task set_mode;
    input [`SCD_MODE_W-1:0] m;
    begin
      op_mode <= m;
      regulator_en <= (m != `SCD_M_DEEP);
      xtal_en <= (m == `SCD_M_STBY) || (m == `SCD_M_PLL) ||
        (m == `SCD_M_RX) || (m == `SCD_M_TX);
      vco_en <= (m == `SCD_M_PLL) || (m == `SCD_M_RX) || (m == `SCD_M_TX);
      pll_en <= (m == `SCD_M_PLL) || (m == `SCD_M_RX) || (m == `SCD_M_TX);
      rx_en <= (m == `SCD_M_RX);
      tx_en <= (m == `SCD_M_TX);
      // any mode change releases the pins; deep sleep sets its own pin state after this
      io_tri_r <= 1'b0;
      io_pull_r <= 1'b0;
    end
  endtask

  // main serial engine; the software reset re-initialises id, mode, pins and phase, not the shift and count flops
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_d_r <= 1'b0;
      st_r <= ST_CMD;
      bitcnt_r <= 3'd0;
      shift_r <= 8'h00;
      addr_r <= 8'h00;
      bytecnt_r <= 2'd0;
      rd_shift_r <= 8'h00;
      rd_active_r <= 1'b0;
      srst_cnt_r <= 4'h0;
      io_tri_r <= 1'b0;
      io_pull_r <= 1'b0;
      rx_fifo_pop <= 1'b0;
      tx_fifo_data <= 8'h00;
      tx_fifo_push <= 1'b0;
      fifo_wptr_rst <= 1'b0;
      fifo_rptr_rst <= 1'b0;
      id_value <= `SCD_ID_RST;
      op_mode <= `SCD_M_STBY;
      regulator_en <= 1'b1;
      xtal_en <= 1'b1;
      vco_en <= 1'b0;
      pll_en <= 1'b0;
      rx_en <= 1'b0;
      tx_en <= 1'b0;
      recal_needed <= 1'b1;
      internal_reset_n <= 1'b1;
    end else begin
      // edge history advances every cycle, the reset pulse included
      sck_d_r <= sck_s;
      rx_fifo_pop <= 1'b0;
      tx_fifo_push <= 1'b0;
      fifo_wptr_rst <= 1'b0;
      fifo_rptr_rst <= 1'b0;
      internal_reset_n <= ~srst_busy;
      if (srst_busy) begin
        // internal reset pulse: registers back to initial values, standby
        // bit count left alone: the host closes the frame with select anyway
        srst_cnt_r <= srst_cnt_r - 4'h1;
        id_value <= `SCD_ID_RST;
        set_mode(`SCD_M_STBY);
        recal_needed <= 1'b1;
        io_tri_r <= 1'b0;
        io_pull_r <= 1'b0;
        st_r <= ST_CMD;
        rd_active_r <= 1'b0;
      end else if (!active) begin
        // select high ends or aborts whatever was under way
        st_r <= ST_CMD;
        bitcnt_r <= 3'd0;
        bytecnt_r <= 2'd0;
        rd_active_r <= 1'b0;
      end else if (sck_rise) begin
        shift_r <= byte_in;
        bitcnt_r <= bitcnt_r + 3'd1;
        case (st_r)
          ST_CMD: begin
            // 4th bit of a strobe carries the nibble
            if (bitcnt_r == 3'd3 && byte_in[3] && strobes_on) begin
              case (byte_in[3:0])
                `SCD_STB_SLEEP: set_mode(`SCD_M_SLEEP);
                `SCD_STB_IDLE: set_mode(`SCD_M_IDLE);
                `SCD_STB_STBY: set_mode(`SCD_M_STBY);
                `SCD_STB_PLL: set_mode(`SCD_M_PLL);
                `SCD_STB_RX: set_mode(`SCD_M_RX);
                `SCD_STB_TX: set_mode(`SCD_M_TX);
                `SCD_STB_WPRST: fifo_wptr_rst <= 1'b1;
                default: fifo_rptr_rst <= 1'b1;
              endcase
            end
            // eighth bit: deep sleep codes or the register address
            if (bitcnt_r == 3'd7) begin
              if (byte_in[`SCD_CMD_BIT]) begin
                // low nibble ignored except deep sleep codes
                if (strobes_on && byte_in == `SCD_DS_TRI) begin
                  set_mode(`SCD_M_DEEP);
                  io_tri_r <= 1'b1;
                  io_pull_r <= 1'b0;
                  id_value <= `SCD_ID_RST;
                  recal_needed <= 1'b1;
                end else if (strobes_on && byte_in == `SCD_DS_PULL) begin
                  set_mode(`SCD_M_DEEP);
                  io_tri_r <= 1'b0;
                  io_pull_r <= 1'b1;
                  id_value <= `SCD_ID_RST;
                  recal_needed <= 1'b1;
                end
              end else begin
                addr_r <= byte_in;
                bytecnt_r <= 2'd0;
                if (byte_in[`SCD_RW_BIT]) begin
                  st_r <= ST_RDATA;
                  rd_active_r <= 1'b1;
                  if (byte_in[5:0] == `SCD_ADDR_ID) begin
                    rd_shift_r <= id_byte(id_value, 2'd0);
                  end else begin
                    // staged now so its msb is out before the first data rising edge
                    rd_shift_r <= rx_fifo_data;
                    // no pop yet: a byte counts as taken only once it has gone out
                  end
                end else begin
                  st_r <= ST_WDATA;
                end
              end
            end
          end
          ST_WDATA: begin
            if (bitcnt_r == 3'd7) begin
              if (addr_r[5:0] == `SCD_ADDR_RST && byte_in == 8'h00 &&
                  bytecnt_r == 2'd0) begin
                srst_cnt_r <= SRST_CYCLES[3:0];
              end else if (addr_r[5:0] == `SCD_ADDR_ID) begin
                // bytes 0..3 fill from the top, extra bytes ignored
                case (bytecnt_r)
                  2'd0: id_value[31:24] <= byte_in;
                  2'd1: id_value[23:16] <= byte_in;
                  2'd2: id_value[15:8] <= byte_in;
                  default: id_value[7:0] <= byte_in;
                endcase
                if (bytecnt_r == 2'd3) begin
                  st_r <= ST_DONE;
                end
              end else if (addr_r[5:0] == `SCD_ADDR_FIFO) begin
                tx_fifo_data <= byte_in;
                tx_fifo_push <= fifo_data_mode;
              end
              bytecnt_r <= bytecnt_r + 2'd1;
            end
          end
          ST_RDATA: begin
            // next read byte staged after the last bit is clocked in
            if (bitcnt_r == 3'd7) begin
              bytecnt_r <= bytecnt_r + 2'd1;
              if (addr_r[5:0] == `SCD_ADDR_ID) begin
                if (bytecnt_r == 2'd3) begin
                  st_r <= ST_DONE;
                end else begin
                  rd_shift_r <= id_byte(id_value, bytecnt_r + 2'd1);
                end
              end else begin
                // byte fully sent: pop it; the next head is staged on the falling edge
                rx_fifo_pop <= fifo_data_mode;
              end
            end
          end
          default: begin
            st_r <= ST_DONE; // extra bits ignored until select rises
          end
        endcase
      end else if (sck_fall && rd_active_r && st_r == ST_RDATA) begin
        if (bitcnt_r != 3'd0) begin
          rd_shift_r <= {rd_shift_r[6:0], 1'b0};
        end else if (addr_r[5:0] != `SCD_ADDR_ID) begin
          // the fifo head has settled since the pop at the last rising edge
          rd_shift_r <= rx_fifo_data;
        end
      end
      // deep sleep codes pass through sleep first, so a set never meets this clear
      if (!srst_busy && rx_en | tx_en) begin
        recal_needed <= 1'b0; // the synthesizer runs, calibration done
      end
    end
  end

  // pin drive: sdio returns read data, outputs give fifo status or spi data
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_data_out <= 1'b0;
      serial_data_oe_n <= 1'b1;
      fifo_data_mode <= 1'b0;
      general_output_1 <= 1'b0;
      general_output_1_oe_n <= 1'b0;
      general_output_1_pullup <= 1'b0;
      general_output_2 <= 1'b0;
      general_output_2_oe_n <= 1'b0;
      general_output_2_pullup <= 1'b0;
    end else begin
      // mode select comes from logic on this clock, so no synchroniser
      fifo_data_mode <= fifo_mode_select;
      serial_data_out <= rd_shift_r[7];
      serial_data_oe_n <= ~(rd_active_r & active);
      general_output_1 <= (output1_function_select == `SCD_GSEL_FIFO) ? fifo_status :
        (output1_function_select == `SCD_GSEL_SDO) ? rd_shift_r[7] : 1'b0;
      general_output_2 <= (output2_function_select == `SCD_GSEL_FIFO) ? fifo_status :
        (output2_function_select == `SCD_GSEL_SDO) ? rd_shift_r[7] : 1'b0;
      // pins float only in deep sleep, with or without the pull-ups
      general_output_1_oe_n <= io_tri_r | io_pull_r;
      general_output_2_oe_n <= io_tri_r | io_pull_r;
      general_output_1_pullup <= io_pull_r;
      general_output_2_pullup <= io_pull_r;
    end
  end
endmodule // scd_strobe_decoder

// *** tb/scd_sd_assertions.sv ***
/*
  port-level checks of the strobe command decoder, bound into it.
  assumes one core clock domain and an asynchronous active-low rst_n.
*/
`timescale 1ns/1ps
module scd_sd_assertions #(
  parameter int SRST_CYCLES = 4
) (
  input wire core_clk,
  input wire rst_n,
  input wire fifo_mode_select,
  input wire [3:0] output1_function_select,
  input wire [3:0] output2_function_select,
  input wire fifo_status,
  input wire fifo_data_mode,
  input wire tx_fifo_push,
  input wire rx_fifo_pop,
  input wire internal_reset_n,
  input wire [7:0] op_mode,
  input wire regulator_en,
  input wire xtal_en,
  input wire vco_en,
  input wire pll_en,
  input wire rx_en,
  input wire tx_en,
  input wire general_output_1,
  input wire general_output_2,
  input wire general_output_1_pullup
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] low_cnt_r;
  // length of the internal reset pulse, counted so a parameter can set it
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) low_cnt_r <= 8'h00;
    else if (!internal_reset_n) low_cnt_r <= low_cnt_r + 8'h01;
    else low_cnt_r <= 8'h00;
  end
  srst_len_a: assert property ($rose(internal_reset_n) |-> low_cnt_r == SRST_CYCLES)
    else $error("internal reset pulse has wrong length");
  srst_stby_a: assert property ($rose(internal_reset_n) |-> op_mode == 8'h08)
    else $error("not in standby after internal reset");
  deep_off_a: assert property (op_mode == 8'h01 |-> !regulator_en && !xtal_en && !vco_en)
    else $error("deep sleep left a supply on");
  sleep_off_a: assert property (op_mode == 8'h02 |-> regulator_en && !xtal_en && !pll_en)
    else $error("sleep enables wrong");
  idle_off_a: assert property (op_mode == 8'h04 |-> regulator_en && !xtal_en && !rx_en)
    else $error("idle enables wrong");
  stby_en_a: assert property (op_mode == 8'h08 |-> xtal_en && !vco_en && !tx_en)
    else $error("standby enables wrong");
  pll_en_a: assert property (op_mode == 8'h10 |-> vco_en && pll_en && !rx_en && !tx_en)
    else $error("pll mode enables wrong");
  rx_only_a: assert property (op_mode == 8'h20 |-> pll_en && rx_en && !tx_en)
    else $error("receive mode enables wrong");
  tx_only_a: assert property (op_mode == 8'h40 |-> pll_en && tx_en && !rx_en)
    else $error("transmit mode enables wrong");
  fifo_mode_a: assert property ($changed(fifo_mode_select) |=>
    fifo_data_mode == $past(fifo_mode_select))
    else $error("data mode does not follow select");
  push_mode_a: assert property (tx_fifo_push |-> fifo_data_mode)
    else $error("push outside fifo mode");
  pop_mode_a: assert property (rx_fifo_pop |-> fifo_data_mode)
    else $error("pop outside fifo mode");
  gio_stat_a: assert property (output1_function_select == 4'h1 && op_mode != 8'h01 |=>
    op_mode == 8'h01 || general_output_1 == $past(fifo_status))
    else $error("fifo status not on output");
  general_output_2_stat_a: assert property (output2_function_select == 4'h1 && op_mode != 8'h01 |=>
    op_mode == 8'h01 || general_output_2 == $past(fifo_status))
    else $error("fifo status not on second output");
  pull_off_a: assert property (op_mode != 8'h01 && $past(op_mode) != 8'h01 |->
    !general_output_1_pullup)
    else $error("pull-up left on outside deep sleep");
  // main scenarios reached
  cover property (op_mode == 8'h20);
  cover property (op_mode == 8'h01 && general_output_1_pullup);
  cover property ($fell(internal_reset_n));
  cover property (tx_fifo_push);
endmodule // scd_sd_assertions

bind scd_strobe_decoder scd_sd_assertions #(.SRST_CYCLES(SRST_CYCLES)) u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .fifo_mode_select(fifo_mode_select),
  .output1_function_select(output1_function_select),
  .output2_function_select(output2_function_select), .fifo_status(fifo_status),
  .fifo_data_mode(fifo_data_mode), .tx_fifo_push(tx_fifo_push), .rx_fifo_pop(rx_fifo_pop),
  .internal_reset_n(internal_reset_n), .op_mode(op_mode), .regulator_en(regulator_en),
  .xtal_en(xtal_en), .vco_en(vco_en), .pll_en(pll_en), .rx_en(rx_en), .tx_en(tx_en),
  .general_output_1(general_output_1), .general_output_2(general_output_2),
  .general_output_1_pullup(general_output_1_pullup));

// *** tb/scd_host_model.sv ***
/*
  host side of the serial command link: select, serial clock and data.
  assumes the bench resolves the shared data pin into sdio.
*/
`timescale 1ns/1ps
module scd_host_model (
  input wire core_clk,
  input wire sdio,
  output logic serial_select_n,
  output logic serial_clk,
  output logic host_data
);
  initial begin
    serial_select_n = 1'b1;
    serial_clk = 1'b0;
    host_data = 1'b0;
  end
  // half a serial clock period: 160 ns per bit
  task automatic half;
    repeat (8) @(negedge core_clk);
  endtask
  // one framed transfer, msb first; clock idles low outside frames
  task automatic frame(input logic [39:0] v, input int n, output logic [39:0] rd);
    rd = 40'h0;
    serial_select_n = 1'b0;
    half();
    for (int i = n - 1; i >= 0; i--) begin
      host_data = v[i];
      half();
      serial_clk = 1'b1;
      rd = {rd[38:0], sdio};
      half();
      serial_clk = 1'b0;
    end
    serial_select_n = 1'b1;
    host_data = ~host_data;
    half();
    half();
  endtask
endmodule // scd_host_model

// *** tb/tb_top.sv ***
/*
  self-checking bench for the strobe command decoder with a host model.
  assumes a 100 MHz core clock and the decoder's registered outputs.
*/
`timescale 1ns/1ps
module tb_top;
  logic core_clk, rst_n, alt_strobe_cfg_a, alt_strobe_cfg_b, fifo_mode_select, fifo_status;
  logic [3:0] output1_function_select, output2_function_select;
  logic [7:0] rx_fifo_data, last_mode;
  logic [39:0] rd;
  logic [31:0] id, r, got;
  integer seed, errors, tests_run;
  logic [31:0] expq[$];
  wire serial_select_n, serial_clk, host_data, serial_data_out, serial_data_oe_n, rx_fifo_pop;
  wire tx_fifo_push, fifo_wptr_rst, fifo_rptr_rst, fifo_data_mode, recal_needed;
  wire regulator_en, xtal_en, vco_en, pll_en, rx_en, tx_en, internal_reset_n;
  wire general_output_1, general_output_1_oe_n, general_output_1_pullup;
  wire general_output_2, general_output_2_oe_n, general_output_2_pullup;
  wire [7:0] tx_fifo_data, op_mode;
  wire [31:0] id_value;
  // shared data pin: device wins while its enable is low
  wire serial_data_in = (serial_data_oe_n === 1'b0) ? serial_data_out : host_data;

  scd_strobe_decoder #(.SRST_CYCLES(4)) dut (.core_clk(core_clk), .rst_n(rst_n),
    .serial_select_n(serial_select_n), .serial_clk(serial_clk),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
    .serial_data_oe_n(serial_data_oe_n), .alt_strobe_cfg_a(alt_strobe_cfg_a),
    .alt_strobe_cfg_b(alt_strobe_cfg_b), .fifo_mode_select(fifo_mode_select),
    .output1_function_select(output1_function_select),
    .output2_function_select(output2_function_select), .fifo_status(fifo_status),
    .rx_fifo_data(rx_fifo_data), .rx_fifo_pop(rx_fifo_pop), .tx_fifo_data(tx_fifo_data),
    .tx_fifo_push(tx_fifo_push), .fifo_wptr_rst(fifo_wptr_rst),
    .fifo_rptr_rst(fifo_rptr_rst), .fifo_data_mode(fifo_data_mode), .id_value(id_value),
    .op_mode(op_mode), .regulator_en(regulator_en), .xtal_en(xtal_en), .vco_en(vco_en),
    .pll_en(pll_en), .rx_en(rx_en), .tx_en(tx_en), .recal_needed(recal_needed),
    .internal_reset_n(internal_reset_n), .general_output_1(general_output_1),
    .general_output_1_oe_n(general_output_1_oe_n),
    .general_output_1_pullup(general_output_1_pullup),
    .general_output_2(general_output_2), .general_output_2_oe_n(general_output_2_oe_n),
    .general_output_2_pullup(general_output_2_pullup));
  scd_host_model h (.core_clk(core_clk), .sdio(serial_data_in),
    .serial_select_n(serial_select_n), .serial_clk(serial_clk), .host_data(host_data));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // expected mode note: enables {regulator, xtal, vco, pll, rx, tx} then mode
  function automatic logic [31:0] mnote(input logic [7:0] m);
    logic [5:0] e;
    case (m)
      8'h01: e = 6'b000000;
      8'h02, 8'h04: e = 6'b100000;
      8'h08: e = 6'b110000;
      8'h10: e = 6'b111100;
      8'h20: e = 6'b111110;
      default: e = 6'b111101;
    endcase
    return {8'h01, 10'h000, e, m};
  endfunction
  task automatic stb(input logic [3:0] nib);
    h.frame({36'h0, nib}, 4, rd);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // watcher: each visible result takes the oldest note off the queue
  always @(negedge core_clk) begin
    if (rst_n === 1'b1) begin
      if (op_mode !== last_mode) begin
        got = {8'h01, 10'h000, regulator_en, xtal_en, vco_en, pll_en, rx_en, tx_en, op_mode};
        chk(got, expq.size() ? expq.pop_front() : 32'hFFFFFFFF);
      end
      if (fifo_wptr_rst !== 1'b0)
        chk(32'h02000000, expq.size() ? expq.pop_front() : 32'h0);
      if (fifo_rptr_rst !== 1'b0)
        chk(32'h03000000, expq.size() ? expq.pop_front() : 32'h0);
      if (tx_fifo_push !== 1'b0)
        chk({24'h040000, tx_fifo_data}, expq.size() ? expq.pop_front() : 32'h0);
      if (rx_fifo_pop !== 1'b0)
        chk(32'h05000000, expq.size() ? expq.pop_front() : 32'h0);
      last_mode = op_mode;
    end
  end
  // status input wanders so the output path is exercised
  always @(negedge core_clk) fifo_status <= 1'($random(seed));
  // hang guard
  initial begin
    #800000;
    errors++;
    results();
  end
  initial begin
    seed = 32'h2139;
    errors = 0;
    tests_run = 0;
    last_mode = 8'h08;
    {rst_n, alt_strobe_cfg_a, alt_strobe_cfg_b, fifo_mode_select} = 4'h0;
    output1_function_select = 4'h1;
    output2_function_select = 4'h1;
    rx_fifo_data = 8'h00;
    idle(16);
    rst_n = 1'b1;
    idle(4);
    chk({recal_needed, internal_reset_n, op_mode}, {2'b11, 8'h08});
    for (int i = 0; i < 6; i++) begin
      r = {8'h10, 8'h20, 8'h40, 8'h04, 8'h02, 8'h08} >> (8 * (5 - i));
      expq.push_back(mnote(r[7:0]));
      stb({4'hB, 4'hC, 4'hD, 4'h9, 4'h8, 4'hA} >> (4 * (5 - i)));
    end
    expq.push_back(32'h02000000);
    stb(4'hE);
    expq.push_back(32'h03000000);
    stb(4'hF);
    r = $random(seed);
    expq.push_back(mnote(8'h10));
    expq.push_back(mnote(8'h20));
    h.frame({24'h0, 4'hB, r[3:0], 4'hC, r[7:4]}, 16, rd);
    h.frame(40'h3, 2, rd);
    expq.push_back(mnote(8'h04));
    stb(4'h9);
    alt_strobe_cfg_a = 1'b1;
    stb(4'hD);
    alt_strobe_cfg_a = 1'b0;
    alt_strobe_cfg_b = 1'b1;
    stb(4'hC);
    alt_strobe_cfg_b = 1'b0;
    id = {4'h5, 28'($random(seed))};
    h.frame({8'h06, id}, 40, rd);
    chk(id_value, id);
    h.frame({8'h46, 32'h0}, 40, rd);
    chk(rd[31:0], id);
    fifo_mode_select = 1'b1;
    idle(3);
    expq.push_back({24'h040000, r[15:8]});
    expq.push_back({24'h040000, r[23:16]});
    h.frame({16'h0, 8'h05, r[15:8], r[23:16]}, 24, rd);
    rx_fifo_data = r[31:24];
    expq.push_back(32'h05000000);
    h.frame({24'h0, 8'h45, 8'h0}, 16, rd);
    chk(rd[7:0], r[31:24]);
    fifo_mode_select = 1'b0;
    idle(3);
    h.frame({24'h0, 8'h05, 8'hA5}, 16, rd);
    expq.push_back(mnote(8'h02));
    expq.push_back(mnote(8'h01));
    h.frame({32'h0, 8'h88}, 8, rd);
    chk({general_output_1_oe_n, general_output_2_oe_n}, 2'b11);
    chk({recal_needed, id_value}, {1'b1, 32'h0});
    expq.push_back(mnote(8'h02));
    expq.push_back(mnote(8'h01));
    h.frame({32'h0, 8'h8B}, 8, rd);
    chk({general_output_1_pullup, general_output_2_pullup}, 2'b11);
    expq.push_back(mnote(8'h08));
    stb(4'hA);
    chk({general_output_1_oe_n, general_output_2_oe_n, general_output_1_pullup,
      general_output_2_pullup}, 4'h0);
    expq.push_back(mnote(8'h20));
    stb(4'hC);
    expq.push_back(mnote(8'h08));
    h.frame(40'h0, 16, rd);
    idle(10);
    chk({recal_needed, internal_reset_n}, 2'b11);
    idle(20);
    chk(expq.size(), 0);
    results();
  end
endmodule // tb_top
